// File: include/bfac_map.vh
// Register offsets, field positions, limits and counts of the feedback control block
`ifndef BFAC_MAP_VH
`define BFAC_MAP_VH
// Register byte offsets
`define BFAC_CTRL_OFS       8'h00
`define BFAC_GAIN_OFS       8'h04
`define BFAC_SATTHR_OFS     8'h08
`define BFAC_SATRES_OFS     8'h0C
`define BFAC_ACQCFG_OFS     8'h10
`define BFAC_RECLEN_OFS     8'h14
`define BFAC_GROWLEN_OFS    8'h18
`define BFAC_HOLDOFF_OFS    8'h1C
`define BFAC_CMD_OFS        8'h20
`define BFAC_STATUS_OFS     8'h24
`define BFAC_ERRCNT_OFS     8'h28
`define BFAC_INTERVAL_OFS   8'h2C
`define BFAC_DELAY_OFS      8'h30
`define BFAC_COEFF_SEL_OFS  8'h34
`define BFAC_COEFF_DATA_OFS 8'h38
`define BFAC_MEMRD_ADDR_OFS 8'h3C
`define BFAC_MEMRD_DATA_OFS 8'h40
// CTRL fields
`define BFAC_CTRL_FB_EN     0
`define BFAC_CTRL_COEFF_SET 1
`define BFAC_CTRL_SWITCH_EN 2
`define BFAC_CTRL_TRIG_EXT  3
`define BFAC_CTRL_REARM     4
`define BFAC_CTRL_MEM_SRAM  5
// CMD fields (write one to act)
`define BFAC_CMD_ACQUIRE    0
`define BFAC_CMD_ARM        1
`define BFAC_CMD_CNT_RST    2
`define BFAC_CMD_CM_RST     3
`define BFAC_CMD_READ_DONE  4
// Limits and sizes
`define BFAC_BRAM_MAX       24'd131072
`define BFAC_SRAM_MAX       24'd8388608
`define BFAC_BRAM_DEPTH     1024
`define BFAC_BRAM_AW        10
`define BFAC_NTAPS          8
`define BFAC_HOLD_GROUP     2
`define BFAC_MAX_ODELAY     16
`define BFAC_CM_RST_CYC     4'h8
`define BFAC_POLL_CYC       24'd10000000
`endif

// File: src/bfac_top.v
// Feedback processor control: output path, saturation monitor, acquisition, status
`include "bfac_map.vh"

// How it works
// - Filter reaches DAC only while feedback enabled
// - Gain shift doubles output per step
// - Saturated samples counted against duty threshold
// - Poll read returns result, clears counter
// - Zero threshold flags any single saturation
// - Coefficient switching only when enabled
// - Acquisition decimation independent of processing
// - Record length clipped per memory target
// - Grow length inverts set select
// - Hold-off inverts select, groups of four
// - Trigger from host command or input
// - External trigger needs arm, single shot
// - Automatic_rearm after each readout
// - Samples go to block or SRAM
// - Clock missing and lock-loss flags
// - Fiducial missing or jitter flag
// - Counter reset clears errors, interval
// - DAC output delayed whole periods
// - Fiducial delayed in two-bunch steps
// - Two coefficient sets, writable, readable
// - Clock manager reset resets both
module bfac_top (
  input  wire        clock,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire [15:0] filter_result,
  input  wire        filter_valid,
  input  wire [15:0] adc_sample,
  input  wire        proc_decim_tick,
  output reg  [15:0] dac_data,
  output wire        coeff_set_active,
  output wire [15:0] coeff_tap_data,
  input  wire [2:0]  coeff_tap_sel,
  input  wire        rf_clock_present,
  input  wire        processing_clock_manager_locked,
  input  wire        acquisition_clock_manager_locked,
  output wire        processing_clock_manager_rst,
  output wire        acquisition_clock_manager_rst,
  input  wire        fiducial_in,
  output reg         fiducial_delayed,
  input  wire        external_trigger_input,
  output reg         sram_we,
  output reg  [22:0] sram_addr,
  output reg  [15:0] sram_wdata
);

  ////////////////////////////////////////////////////////////////////////
  // Acquisition states
  localparam ST_IDLE = 2'b00;
  localparam ST_HOLD = 2'b01;
  localparam ST_REC  = 2'b10;

  // Software registers
  reg  [5:0]  ctrl_reg;
  reg  [3:0]  gain_reg;
  reg  [6:0]  satthr_reg;
  reg  [15:0] acqcfg_reg;
  reg  [23:0] reclen_reg;
  reg  [23:0] growlen_reg;
  reg  [15:0] holdoff_reg;
  reg  [4:0]  odelay_reg;
  reg  [7:0]  fdelay_reg;
  reg  [3:0]  coeff_sel_reg;
  reg  [`BFAC_BRAM_AW-1:0] memrd_addr_reg;
  reg  [15:0] coeff_mem [0:2*`BFAC_NTAPS-1];
  reg  [15:0] bram [0:`BFAC_BRAM_DEPTH-1];

  // Bus phase registers
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;

  // Input synchronisers
  reg  [4:0]  sync1_reg;
  reg  [4:0]  sync2_reg;
  wire        trig_s   = sync2_reg[0];
  wire        fid_s    = sync2_reg[1];
  wire        rf_ok_s  = sync2_reg[2];
  wire        pcm_ok_s = sync2_reg[3];
  wire        acm_ok_s = sync2_reg[4];

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire   ahb_go    = hsel & hready & htrans[1];
  wire   wr_go     = wr_pend_reg;
  wire   rd_go     = ahb_go & ~hwrite;
  wire   poll_rd   = rd_go & (haddr == `BFAC_SATRES_OFS);
  wire   cmd_wr    = wr_go & (wr_addr_reg == `BFAC_CMD_OFS);
  wire   cmd_acq   = cmd_wr & hwdata[`BFAC_CMD_ACQUIRE];
  wire   cmd_arm   = cmd_wr & hwdata[`BFAC_CMD_ARM];
  wire   cmd_crst  = cmd_wr & hwdata[`BFAC_CMD_CNT_RST];
  wire   cmd_cmrst = cmd_wr & hwdata[`BFAC_CMD_CM_RST];
  wire   cmd_rdone = cmd_wr & hwdata[`BFAC_CMD_READ_DONE];

  // Address phase capture for writes
  always @(posedge clock) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= ahb_go & hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // Write data phase into configuration
  always @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg       <= 6'h00;
      gain_reg       <= 4'h0;
      satthr_reg     <= 7'h00;
      acqcfg_reg     <= 16'h0000;
      reclen_reg     <= 24'h000400;
      growlen_reg    <= 24'h000000;
      holdoff_reg    <= 16'h0000;
      odelay_reg     <= 5'h00;
      fdelay_reg     <= 8'h00;
      coeff_sel_reg  <= 4'h0;
      memrd_addr_reg <= {`BFAC_BRAM_AW{1'b0}};
    end else if (wr_go) begin
      case (wr_addr_reg)
        `BFAC_CTRL_OFS:       ctrl_reg <= hwdata[5:0];
        `BFAC_GAIN_OFS:       gain_reg <= hwdata[3:0];
        `BFAC_SATTHR_OFS:     satthr_reg <= (hwdata[6:0] > 7'h64) ? 7'h64 : hwdata[6:0];
        `BFAC_ACQCFG_OFS:     acqcfg_reg <= hwdata[15:0];
        `BFAC_RECLEN_OFS:     reclen_reg <= hwdata[23:0];
        `BFAC_GROWLEN_OFS:    growlen_reg <= hwdata[23:0];
        `BFAC_HOLDOFF_OFS:    holdoff_reg <= hwdata[15:0];
        `BFAC_DELAY_OFS: begin
          odelay_reg <= (hwdata[4:0] > 5'h0F) ? 5'h0F : hwdata[4:0];
          fdelay_reg <= hwdata[15:8];
        end
        `BFAC_COEFF_SEL_OFS:  coeff_sel_reg <= hwdata[3:0];
        `BFAC_MEMRD_ADDR_OFS: memrd_addr_reg <= hwdata[`BFAC_BRAM_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Coefficient storage, set in bit 3 of the select
  always @(posedge clock) begin
    if (wr_go && wr_addr_reg == `BFAC_COEFF_DATA_OFS)
      coeff_mem[coeff_sel_reg] <= hwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pins
  always @(posedge clock) begin
    if (!rstn) begin
      sync1_reg <= 5'h1C; // Idle levels of the pins
      sync2_reg <= 5'h1C;
    end else begin
      sync1_reg <= {acquisition_clock_manager_locked, processing_clock_manager_locked,
                    rf_clock_present, fiducial_in, external_trigger_input};
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output path: enable, gain shift, delay line
  reg  [15:0] odly [0:`BFAC_MAX_ODELAY-1];
  reg  [15:0] shifted;
  reg         sat_now;
  reg  [31:0] wide;
  integer     i;

  // Arithmetic shift with saturation
  always @* begin
    wide    = {{16{filter_result[15]}}, filter_result} <<< gain_reg;
    sat_now = (wide[31:15] != {17{wide[31]}});
    if (!sat_now)
      shifted = wide[15:0];
    else if (wide[31])
      shifted = 16'h8000;
    else
      shifted = 16'h7FFF;
  end

  // Delay line stage 0 takes gated filter output
  always @(posedge clock) begin
    if (!rstn) begin
      for (i = 0; i < `BFAC_MAX_ODELAY; i = i + 1)
        odly[i] <= 16'h0000;
      dac_data <= 16'h0000;
    end else begin
      odly[0] <= ctrl_reg[`BFAC_CTRL_FB_EN] ? shifted : 16'h0000;
      for (i = 1; i < `BFAC_MAX_ODELAY; i = i + 1)
        odly[i] <= odly[i-1];
      dac_data <= (odelay_reg == 5'h00) ? (ctrl_reg[`BFAC_CTRL_FB_EN] ? shifted : 16'h0000)
                                        : odly[odelay_reg[3:0]-4'h1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Saturation monitor
  reg  [23:0] sat_cnt_reg;
  reg  [23:0] poll_cnt_reg;
  reg  [30:0] thr_prod;
  reg  [30:0] sat_prod;
  wire        sat_flag = (satthr_reg == 7'h00) ? (sat_cnt_reg != 24'h000000)
                                               : (sat_prod >= thr_prod);

  // Duty compare: count*100 against threshold*samples
  always @* begin
    sat_prod = {sat_cnt_reg, 7'h00} - {2'b00, sat_cnt_reg, 5'h00}
             + {5'h00, sat_cnt_reg, 2'b00};
    thr_prod = satthr_reg * poll_cnt_reg;
  end

  // Counter; a poll read clears, a sample in that cycle is kept
  always @(posedge clock) begin
    if (!rstn) begin
      sat_cnt_reg  <= 24'h000000;
      poll_cnt_reg <= 24'h000000;
    end else if (poll_rd) begin
      sat_cnt_reg  <= (filter_valid && sat_now) ? 24'h000001 : 24'h000000;
      poll_cnt_reg <= filter_valid ? 24'h000001 : 24'h000000;
    end else if (filter_valid) begin
      if (sat_now && sat_cnt_reg != 24'hFFFFFF)
        sat_cnt_reg <= sat_cnt_reg + 24'h000001;
      if (poll_cnt_reg != 24'hFFFFFF)
        poll_cnt_reg <= poll_cnt_reg + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fiducial delay, error detect, status and counters
  reg  [255:0] fid_sr_reg;
  reg          fid_prev_reg;
  reg  [23:0]  fid_gap_reg;
  reg  [23:0]  fid_period_reg;
  reg          fid_err_reg;
  reg  [15:0]  err_cnt_reg;
  reg  [31:0]  interval_reg;
  reg  [23:0]  tick_reg;
  reg  [3:0]   cm_rst_cnt_reg;
  wire         fid_rise = fid_s & ~fid_prev_reg;
  wire         any_err  = fid_err_reg | ~rf_ok_s | ~pcm_ok_s | ~acm_ok_s;

  // Shift register tapped at twice the programmed step
  always @(posedge clock) begin
    if (!rstn) begin
      fid_sr_reg       <= 256'd0;
      fiducial_delayed <= 1'b0;
    end else begin
      fid_sr_reg       <= {fid_sr_reg[254:0], fid_s};
      fiducial_delayed <= (fdelay_reg == 8'h00) ? fid_s
                          : fid_sr_reg[{fdelay_reg[6:0], 1'b0} - 8'h01];
    end
  end

  // Period check: missing or changed spacing flags an error
  always @(posedge clock) begin
    if (!rstn) begin
      fid_prev_reg   <= 1'b0;
      fid_gap_reg    <= 24'h000000;
      fid_period_reg <= 24'h000000;
      fid_err_reg    <= 1'b0;
    end else begin
      fid_prev_reg <= fid_s;
      if (fid_rise) begin
        fid_gap_reg    <= 24'h000001;
        fid_period_reg <= fid_gap_reg;
        fid_err_reg    <= (fid_period_reg != 24'h000000) && (fid_gap_reg != fid_period_reg);
      end else if (fid_gap_reg == 24'hFFFFFF) begin
        fid_err_reg <= 1'b1;
      end else begin
        fid_gap_reg <= fid_gap_reg + 24'h000001;
      end
    end
  end

  // Error and interval counters per poll tick
  always @(posedge clock) begin
    if (!rstn || cmd_crst) begin
      err_cnt_reg  <= 16'h0000;
      interval_reg <= 32'h00000000;
      tick_reg     <= 24'h000000;
    end else if (tick_reg == `BFAC_POLL_CYC - 24'd1) begin
      tick_reg     <= 24'h000000;
      interval_reg <= interval_reg + 32'h00000001;
      if (any_err || sat_flag)
        err_cnt_reg <= err_cnt_reg + 16'h0001;
    end else begin
      tick_reg <= tick_reg + 24'h000001;
    end
  end

  // Clock manager reset pulse stretch
  always @(posedge clock) begin
    if (!rstn)
      cm_rst_cnt_reg <= 4'h0;
    else if (cmd_cmrst)
      cm_rst_cnt_reg <= `BFAC_CM_RST_CYC;
    else if (cm_rst_cnt_reg != 4'h0)
      cm_rst_cnt_reg <= cm_rst_cnt_reg - 4'h1;
  end
  assign processing_clock_manager_rst  = (cm_rst_cnt_reg != 4'h0);
  assign acquisition_clock_manager_rst = (cm_rst_cnt_reg != 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // Acquisition control
  reg  [1:0]  st_reg;
  reg         armed_reg;
  reg         trig_prev_reg;
  reg         done_reg;
  reg  [23:0] samp_cnt_reg;
  reg  [23:0] hold_cnt_reg;
  reg  [15:0] dec_cnt_reg;
  reg         invert_reg;
  wire        use_sram  = ctrl_reg[`BFAC_CTRL_MEM_SRAM];
  wire        trig_rise = trig_s & ~trig_prev_reg;
  wire [23:0] len_lim   = use_sram ? `BFAC_SRAM_MAX : `BFAC_BRAM_MAX;
  wire [23:0] rec_len   = (reclen_reg > len_lim) ? len_lim : reclen_reg;
  wire        ext_fire  = ctrl_reg[`BFAC_CTRL_TRIG_EXT] & armed_reg & trig_rise;
  wire        int_fire  = ~ctrl_reg[`BFAC_CTRL_TRIG_EXT] & cmd_acq;
  wire        fire      = (st_reg == ST_IDLE) & (ext_fire | int_fire);
  wire        dec_tick  = (dec_cnt_reg == acqcfg_reg);
  wire        do_store  = (st_reg == ST_REC) & filter_valid & dec_tick;

  // Set select inverted during hold-off and grow, else programmed
  assign coeff_set_active = ctrl_reg[`BFAC_CTRL_COEFF_SET] ^
                            (ctrl_reg[`BFAC_CTRL_SWITCH_EN] & invert_reg);
  assign coeff_tap_data   = coeff_mem[{coeff_set_active, coeff_tap_sel}];

  // Arm flag: set by command or re-arm, cleared by external trigger
  always @(posedge clock) begin
    if (!rstn) begin
      armed_reg     <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_s;
      if (cmd_arm || (cmd_rdone && ctrl_reg[`BFAC_CTRL_REARM] && done_reg))
        armed_reg <= 1'b1;
      else if (ext_fire && st_reg == ST_IDLE)
        armed_reg <= 1'b0;
    end
  end

  // Hold-off, record and grow sequencing
  always @(posedge clock) begin
    if (!rstn) begin
      st_reg       <= ST_IDLE;
      done_reg     <= 1'b0;
      samp_cnt_reg <= 24'h000000;
      hold_cnt_reg <= 24'h000000;
      dec_cnt_reg  <= 16'h0000;
      invert_reg   <= 1'b0;
    end else begin
      if (cmd_rdone)
        done_reg <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          invert_reg <= 1'b0;
          if (fire) begin
            done_reg     <= 1'b0;
            samp_cnt_reg <= 24'h000000;
            dec_cnt_reg  <= 16'h0000;
            hold_cnt_reg <= {6'h00, holdoff_reg, 2'b00};
            invert_reg   <= (holdoff_reg != 16'h0000) || (growlen_reg != 24'h000000);
            st_reg       <= (holdoff_reg != 16'h0000) ? ST_HOLD : ST_REC;
          end
        end
        ST_HOLD: begin
          if (filter_valid) begin
            if (hold_cnt_reg == 24'h000001) begin
              st_reg     <= ST_REC;
              invert_reg <= (growlen_reg != 24'h000000);
            end
            hold_cnt_reg <= hold_cnt_reg - 24'h000001;
          end
        end
        ST_REC: begin
          if (filter_valid)
            dec_cnt_reg <= dec_tick ? 16'h0000 : dec_cnt_reg + 16'h0001;
          if (do_store) begin
            samp_cnt_reg <= samp_cnt_reg + 24'h000001;
            if (samp_cnt_reg + 24'h000001 >= growlen_reg)
              invert_reg <= 1'b0;
            if (samp_cnt_reg + 24'h000001 >= rec_len) begin
              st_reg   <= ST_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Sample writes to block memory or SRAM port
  always @(posedge clock) begin
    if (do_store && !use_sram)
      bram[samp_cnt_reg[`BFAC_BRAM_AW-1:0]] <= adc_sample;
  end

  always @(posedge clock) begin
    if (!rstn) begin
      sram_we    <= 1'b0;
      sram_addr  <= 23'h000000;
      sram_wdata <= 16'h0000;
    end else begin
      sram_we <= do_store & use_sram;
      if (do_store && use_sram) begin
        sram_addr  <= samp_cnt_reg[22:0];
        sram_wdata <= adc_sample;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered into the data phase
  reg [31:0] rd_next;
  always @* begin
    case (haddr)
      `BFAC_CTRL_OFS:       rd_next = {26'h0, ctrl_reg};
      `BFAC_GAIN_OFS:       rd_next = {28'h0, gain_reg};
      `BFAC_SATTHR_OFS:     rd_next = {25'h0, satthr_reg};
      `BFAC_SATRES_OFS:     rd_next = {7'h0, sat_flag, sat_cnt_reg};
      `BFAC_ACQCFG_OFS:     rd_next = {16'h0, acqcfg_reg};
      `BFAC_RECLEN_OFS:     rd_next = {8'h0, reclen_reg};
      `BFAC_GROWLEN_OFS:    rd_next = {8'h0, growlen_reg};
      `BFAC_HOLDOFF_OFS:    rd_next = {16'h0, holdoff_reg};
      `BFAC_STATUS_OFS:     rd_next = {22'h0, st_reg, done_reg, armed_reg, coeff_set_active,
                                       sat_flag, fid_err_reg, ~acm_ok_s, ~pcm_ok_s,
                                       ~rf_ok_s};
      `BFAC_ERRCNT_OFS:     rd_next = {16'h0, err_cnt_reg};
      `BFAC_INTERVAL_OFS:   rd_next = interval_reg;
      `BFAC_DELAY_OFS:      rd_next = {16'h0, fdelay_reg, 3'h0, odelay_reg};
      `BFAC_COEFF_SEL_OFS:  rd_next = {28'h0, coeff_sel_reg};
      `BFAC_COEFF_DATA_OFS: rd_next = {16'h0, coeff_mem[coeff_sel_reg]};
      `BFAC_MEMRD_ADDR_OFS: rd_next = {22'h0, memrd_addr_reg};
      `BFAC_MEMRD_DATA_OFS: rd_next = {16'h0, bram[memrd_addr_reg]};
      default:              rd_next = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (!rstn)
      hrdata <= 32'h00000000;
    else if (rd_go)
      hrdata <= rd_next;
  end

endmodule // bfac_top

// File: bench/bfac_checker.sv
// Concurrent checks on the ports of the feedback control block
module bfac_checker (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] dac_data,
  input wire logic        coeff_set_active,
  input wire logic        processing_clock_manager_rst,
  input wire logic        acquisition_clock_manager_rst,
  input wire logic        sram_we
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic       wr_q;
  logic [7:0] adr_q;
  logic [5:0] ctrl_q;
  logic [4:0] off_cnt;
  logic [4:0] rst_cnt;
  wire        take    = hsel && hready && htrans[1];
  wire        ctrl_wr = wr_q && adr_q == 8'h00;
  wire        cm_cmd  = wr_q && adr_q == 8'h20 && hwdata[3];
  // Shadow of control writes, idle and pulse counters
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      ctrl_q <= 6'h00;
      off_cnt <= 5'h00;
      rst_cnt <= 5'h00;
    end else begin
      wr_q <= take && hwrite;
      adr_q <= haddr;
      if (ctrl_wr) ctrl_q <= hwdata[5:0];
      off_cnt <= (ctrl_q[0] || ctrl_wr) ? 5'h00 : off_cnt + {4'h0, off_cnt != 5'h1F};
      rst_cnt <= processing_clock_manager_rst ? rst_cnt + 5'h01 : 5'h00;
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_unmapped_zero: assert property (take && !hwrite && haddr > 8'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_fb_off_zero: assert property (off_cnt >= 5'h14 |-> dac_data == 16'h0000)
    else $error("dac driven while feedback off");
  a_cm_rst_pair: assert property (processing_clock_manager_rst == acquisition_clock_manager_rst)
    else $error("clock manager resets differ");
  a_cm_rst_start: assert property (cm_cmd |-> ##[1:3] processing_clock_manager_rst)
    else $error("clock manager reset missing");
  a_cm_rst_len: assert property (rst_cnt <= 5'h08)
    else $error("clock manager reset too long");
  a_sram_target: assert property (sram_we |-> ctrl_q[5])
    else $error("sram written with block target");
  a_coeff_hold: assert property (!ctrl_q[2] && !ctrl_wr |=> $stable(coeff_set_active))
    else $error("coefficient set changed");
  c_cm_cmd: cover property (cm_cmd);
  c_sram_we: cover property (sram_we);
  c_fb_on: cover property (ctrl_wr && hwdata[0]);
endmodule // bfac_checker

bind bfac_top bfac_checker u_chk (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .dac_data(dac_data), .sram_we(sram_we),
  .coeff_set_active(coeff_set_active),
  .processing_clock_manager_rst(processing_clock_manager_rst),
  .acquisition_clock_manager_rst(acquisition_clock_manager_rst));

// File: bench/bfac_frontend.sv
// Model of the filter, converters, fiducial and trigger sources
module bfac_frontend (
  input  wire logic        clock,
  input  wire logic [15:0] fval,
  input  wire logic        rf_ok,
  input  wire logic        trig,
  output logic      [15:0] filter_result,
  output logic             filter_valid,
  output logic      [15:0] adc_sample,
  output logic             fiducial_in,
  output wire logic        rf_present,
  output wire logic        lock_ok,
  output wire logic        ext_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] fid_cnt = 6'h00;
  // Status levels and trigger follow the bench
  assign rf_present = rf_ok;
  assign lock_ok = rf_ok;
  assign ext_trig = trig;
  // One sample each cycle, fiducial at a steady period
  always @(posedge clock) begin
    filter_result <= fval;
    filter_valid <= 1'b1;
    adc_sample <= adc_sample + 16'h0001;
    fid_cnt <= fid_cnt + 6'h01;
    fiducial_in <= fid_cnt == 6'h00;
  end
  initial begin
    filter_result = 16'h0000;
    filter_valid = 1'b0;
    adc_sample = 16'h0000;
    fiducial_in = 1'b0;
  end
endmodule // bfac_frontend

// File: bench/bfac_top_bench.sv
// Self-checking bench for the feedback control block
module bfac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rstn = 0, hsel = 0, hwrite = 0, rf_ok = 1, trig = 0, rd_dph = 0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rng = 34377, d0, d1;
  logic [15:0] fval = 16'h0100, v;
  logic [63:0] expq[$];
  wire  [31:0] hrdata;
  wire  [15:0] fres, adc, dac_data, tap_data, sram_wdata;
  wire  [22:0] sram_addr;
  wire         hreadyout, hresp, fvalid, set_act, pcm_rst, acm_rst, rfp, lock, fid, etrig;
  wire         sram_we, fid_dly;
  int          n_fail = 0, n_checks = 0, n_we = 0, la, lb;
  always #50 clock = ~clock;
  bfac_top uut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .filter_result(fres), .filter_valid(fvalid),
    .adc_sample(adc), .proc_decim_tick(1'b0), .dac_data(dac_data), .coeff_set_active(set_act),
    .coeff_tap_data(tap_data), .coeff_tap_sel(3'h3), .rf_clock_present(rfp),
    .processing_clock_manager_locked(lock), .acquisition_clock_manager_locked(lock),
    .processing_clock_manager_rst(pcm_rst), .acquisition_clock_manager_rst(acm_rst),
    .fiducial_in(fid), .fiducial_delayed(fid_dly), .external_trigger_input(etrig),
    .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata));
  bfac_frontend u_fe (.clock(clock), .fval(fval), .rf_ok(rf_ok), .trig(trig),
    .filter_result(fres), .filter_valid(fvalid), .adc_sample(adc), .fiducial_in(fid),
    .rf_present(rfp), .lock_ok(lock), .ext_trig(etrig));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (k == 50) begin n_fail++; give_verdict(); end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back({m, e & m});
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic dac_to(input logic [15:0] x, input logic [15:0] e, output int lat);
    fval <= x;
    lat = 0;
    do begin @(posedge clock); lat++; end while (dac_data !== e && lat < 200);
    chk("dac_data", {16'h0, e}, {16'h0, dac_data});
  endtask
  task automatic pulse();
    trig <= 1'b1;
    repeat (4) @(posedge clock);
    trig <= 1'b0;
    repeat (40) @(posedge clock);
  endtask
  task automatic fid_lag(output int n);
    for (n = 0; fid !== 1'b1 && n < 99; n++) @(posedge clock);
    for (n = 0; fid_dly !== 1'b1 && n < 99; n++) @(posedge clock);
  endtask
  // Read data monitor against the queue of notes
  always @(posedge clock) begin
    if (rd_dph && hreadyout === 1'b1) begin
      chk("hrdata", expq[0][31:0], hrdata & expq[0][63:32]);
      void'(expq.pop_front());
    end
    if (hreadyout === 1'b1) rd_dph <= hsel && htrans[1] && !hwrite;
  end
  // SRAM write counter
  always @(posedge clock) if (sram_we === 1'b1) n_we <= n_we + 1;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    chk("dac_reset", 32'h0, {16'h0, dac_data});
    rd(8'h80, 32'h0, 32'hFFFFFFFF);
    repeat (30) @(posedge clock);
    chk("dac_off", 32'h0, {16'h0, dac_data});
    bus(8'h00, 1'b1, 32'h1);
    for (int g = 0; g < 4; g++) begin
      bus(8'h04, 1'b1, g);
      v = 16'h0100 | 16'(rnd() & 32'hFF);
      dac_to(v, v << g, la);
    end
    bus(8'h04, 1'b1, 32'h1);
    dac_to(v ^ 16'h0080, (v ^ 16'h0080) << 1, la);
    bus(8'h30, 1'b1, 32'h5);
    repeat (20) @(posedge clock);
    dac_to(v, v << 1, lb);
    dac_to(v ^ 16'h0080, (v ^ 16'h0080) << 1, lb);
    chk("out_delay", la + 5, lb);
    fid_lag(la);
    bus(8'h30, 1'b1, 32'h305);
    fid_lag(lb);
    chk("fid_delay", la + 6, lb);
    bus(8'h08, 1'b1, 32'h0);
    bus(8'h04, 1'b1, 32'hF);
    repeat (10) @(posedge clock);
    rd(8'h0C, 32'h01000000, 32'h01000000);
    bus(8'h04, 1'b1, 32'h0);
    rd(8'h0C, 32'h01000004, 32'h01FFFFFF);
    rd(8'h0C, 32'h0, 32'h00FFFFFF);
    bus(8'h20, 1'b1, 32'h8);
    la = 0;
    while (pcm_rst !== 1'b1 && la < 20) begin @(posedge clock); la++; end
    for (lb = 0; pcm_rst === 1'b1 && lb < 20; lb++) begin
      chk("acq_cm_rst", 32'h1, {31'h0, acm_rst});
      @(posedge clock);
    end
    chk("cm_rst_len", 32'h8, lb);
    rf_ok <= 1'b0;
    repeat (5) @(posedge clock);
    rd(8'h24, 32'h7, 32'h7);
    rf_ok <= 1'b1;
    d0 = rnd() & 32'hFFFF;
    d1 = d0 ^ 32'h5A5A;
    bus(8'h34, 1'b1, 32'h3);
    bus(8'h38, 1'b1, d0);
    bus(8'h34, 1'b1, 32'hB);
    bus(8'h38, 1'b1, d1);
    rd(8'h38, d1, 32'hFFFF);
    bus(8'h34, 1'b1, 32'h3);
    rd(8'h38, d0, 32'hFFFF);
    bus(8'h00, 1'b1, 32'h2);
    @(posedge clock);
    chk("coeff_set_active", 32'h1, {31'h0, set_act});
    chk("coeff_tap_data", d1, {16'h0, tap_data});
    bus(8'h14, 1'b1, 32'h4);
    bus(8'h10, 1'b1, 32'h0);
    bus(8'h18, 1'b1, 32'h0);
    bus(8'h1C, 1'b1, 32'h0);
    bus(8'h00, 1'b1, 32'h28);
    pulse();
    chk("sram_writes", 32'h0, n_we);
    bus(8'h20, 1'b1, 32'h2);
    rd(8'h24, 32'h40, 32'h40);
    pulse();
    rd(8'h24, 32'h0, 32'h40);
    chk("sram_writes", 32'h4, n_we);
    bus(8'h00, 1'b1, 32'h38);
    bus(8'h20, 1'b1, 32'h10);
    rd(8'h24, 32'h40, 32'h40);
    bus(8'h00, 1'b1, 32'h20);
    bus(8'h20, 1'b1, 32'h1);
    repeat (40) @(posedge clock);
    chk("sram_writes", 32'h8, n_we);
    bus(8'h18, 1'b1, 32'h2);
    bus(8'h1C, 1'b1, 32'h1);
    bus(8'h00, 1'b1, 32'h24);
    bus(8'h20, 1'b1, 32'h1);
    repeat (6) @(posedge clock);
    chk("grow_inv", 32'h1, {31'h0, set_act});
    @(posedge clock);
    chk("grow_end", 32'h0, {31'h0, set_act});
    give_verdict();
  end
endmodule // bfac_top_bench
